// ---- dma_cfg_regs.svh ----
// Register indices, field positions, reset values and FIFO levels of the DMA data configuration block.
// Included by the design files; definitions only.
`ifndef DMA_CFG_REGS_SVH
`define DMA_CFG_REGS_SVH

`define DATA_CONFIG_IDX 6'h0e
`define LOOP_TYPE_IDX 6'h13
`define REMOTE_ADDR_IDX 6'h12
`define CFG_STATUS_IDX 6'h14

`define WIDTH_BIT 0
`define LANE_BIT 1
`define WIDE_BIT 2
`define LOOPOFF_BIT 3
`define AUTO_BIT 4
`define FIFO_LO_BIT 5
`define FIFO_HI_BIT 6

`define DATA_CONFIG_RESET 8'h04
`define LOOP_TYPE_RESET 2'h0
`define REMOTE_ADDR_RESET 16'h0000

`define ST_WORD_BIT 0
`define ST_SWAP_BIT 1
`define ST_WIDE_BIT 2
`define ST_BUSY_BIT 3
`define ST_REQ_BIT 4
`define ST_LOOP_BIT 5
`define ST_AUTO_BIT 6

`define RX_LEVEL_CODE0 5'h02
`define RX_LEVEL_CODE1 5'h04
`define RX_LEVEL_CODE2 5'h08
`define RX_LEVEL_CODE3 5'h0c
`define TX_LEVEL_BASE 5'h0d

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- dma_cfg_pkg.sv ----
// Types shared by the DMA data configuration block.
// Used with full package scope; nothing is imported.
package dma_cfg_pkg;

	typedef enum {
		BURST_IDLE,
		BURST_REQ,
		BURST_MOVE
	} burst_state_t;

	typedef enum logic [1:0] {
		LOOP_NORMAL = 2'h0,
		LOOP_CONTROLLER = 2'h1,
		LOOP_ENDEC = 2'h2,
		LOOP_EXTERNAL = 2'h3
	} loop_mode_t;

endpackage

// ---- cfg_if.sv ----
// Configuration handed from the register bank to the burst controller.
// Driven by the register bank, read by the burst controller in the same clock domain.
`timescale 1ns/1ps
interface cfg_if;
	logic word_sel;
	logic lane_swap;
	logic wide_sel;
	logic [1:0] fifo_code;
	logic [15:0] remote_addr;

	modport src (output word_sel, lane_swap, wide_sel, fifo_code, remote_addr);
	modport sink (input word_sel, lane_swap, wide_sel, fifo_code, remote_addr);
endinterface

// ---- dma_burst_ctl.sv ----
// Bus request and burst sequencer for the DMA side.
// Assumes fifo_level counts bytes and bus_grant answers bus_req_reg.
`timescale 1ns/1ps
`include "dma_cfg_regs.svh"
module dma_burst_ctl (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	cfg_if.sink cfg, // Written configuration.
	input wire logic [4:0] fifo_level, // Bytes held in the FIFO.
	input wire logic tx_dir, // High while transmitting.
	input wire logic bus_grant, // Bus granted for the burst.
	input wire logic [15:0] start_addr, // Local start address.
	input wire logic start_load, // Loads start_addr while idle.
	output logic bus_req_reg, // Bus request.
	output logic beat_reg, // One transfer this cycle.
	output logic busy_reg, // Request or burst under way.
	output logic word_act_reg, // Applied transfer width.
	output logic swap_act_reg, // Applied byte-lane order.
	output logic wide_act_reg, // Applied wide addressing.
	output logic [31:0] addr_reg // Address of the current beat.
);
	dma_cfg_pkg::burst_state_t state_reg, state_next;
	logic bus_req_next, beat_next, busy_next, word_act_next, swap_act_next, wide_act_next;
	logic [31:0] addr_next;
	logic [1:0] code_act_reg, code_act_next;
	logic [3:0] count_reg, count_next;
	logic eff_word;
	logic [1:0] eff_code;
	logic [4:0] rx_level, level_need;
	logic [3:0] beats;

	function automatic logic [4:0] rx_bytes(input logic [1:0] code);
		case (code)
			2'h0: rx_bytes = `RX_LEVEL_CODE0;
			2'h1: rx_bytes = `RX_LEVEL_CODE1;
			2'h2: rx_bytes = `RX_LEVEL_CODE2;
			default: rx_bytes = `RX_LEVEL_CODE3;
		endcase
	endfunction

	always_comb begin
		eff_word = (state_reg == dma_cfg_pkg::BURST_IDLE) ? cfg.word_sel : word_act_reg;
		eff_code = (state_reg == dma_cfg_pkg::BURST_IDLE) ? cfg.fifo_code : code_act_reg;
		rx_level = rx_bytes(eff_code);
		level_need = tx_dir ? (`TX_LEVEL_BASE - rx_level) : rx_level;
		beats = eff_word ? rx_level[4:1] : rx_level[3:0];
		state_next = state_reg;
		bus_req_next = bus_req_reg;
		beat_next = 1'b0;
		count_next = count_reg;
		addr_next = addr_reg;
		word_act_next = word_act_reg;
		swap_act_next = swap_act_reg;
		wide_act_next = wide_act_reg;
		code_act_next = code_act_reg;
		case (state_reg)
			dma_cfg_pkg::BURST_IDLE: begin
				// New settings take effect only between bursts.
				word_act_next = cfg.word_sel;
				swap_act_next = cfg.lane_swap;
				wide_act_next = cfg.wide_sel;
				code_act_next = cfg.fifo_code;
				addr_next[31:16] = cfg.wide_sel ? cfg.remote_addr : 16'h0000;
				if (start_load) begin
					addr_next[15:0] = start_addr;
				end
				if (fifo_level >= level_need) begin
					state_next = dma_cfg_pkg::BURST_REQ;
					bus_req_next = 1'b1;
				end
			end
			dma_cfg_pkg::BURST_REQ: begin
				if (bus_grant) begin
					state_next = dma_cfg_pkg::BURST_MOVE;
					beat_next = 1'b1;
					count_next = beats;
				end
			end
			dma_cfg_pkg::BURST_MOVE: begin
				if (count_reg == 4'h1) begin
					state_next = dma_cfg_pkg::BURST_IDLE;
					bus_req_next = 1'b0;
				end else begin
					beat_next = 1'b1;
					count_next = count_reg - 4'h1;
					addr_next[15:0] = addr_reg[15:0] + (word_act_reg ? 16'h0002 : 16'h0001);
				end
			end
			default: begin
				state_next = dma_cfg_pkg::BURST_IDLE;
				bus_req_next = 1'b0;
			end
		endcase
		if (word_act_next) begin
			addr_next[0] = 1'b0;
		end
		busy_next = (state_next != dma_cfg_pkg::BURST_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= dma_cfg_pkg::BURST_IDLE;
			bus_req_reg <= 1'b0;
			beat_reg <= 1'b0;
			busy_reg <= 1'b0;
			count_reg <= 4'h0;
			addr_reg <= 32'h00000000;
			word_act_reg <= 1'b0;
			swap_act_reg <= 1'b0;
			wide_act_reg <= 1'b1;
			code_act_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			bus_req_reg <= bus_req_next;
			beat_reg <= beat_next;
			busy_reg <= busy_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			word_act_reg <= word_act_next;
			swap_act_reg <= swap_act_next;
			wide_act_reg <= wide_act_next;
			code_act_reg <= code_act_next;
		end
	end

	a_word_a0_low: assert property (@(posedge aclk) disable iff (!aresetn)
		word_act_reg |-> addr_reg[0] == 1'b0) else $error("Word mode address bit 0 not low.");
	a_word_step_two: assert property (@(posedge aclk) disable iff (!aresetn)
		beat_reg && $past(beat_reg) && word_act_reg |-> addr_reg[15:0] == $past(addr_reg[15:0]) + 16'h0002)
		else $error("Word burst address did not step by two.");
	a_burst_len_min: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == dma_cfg_pkg::BURST_REQ && bus_grant && code_act_reg == 2'h0 && !word_act_reg
		|=> beat_reg [*2] ##1 !beat_reg) else $error("Byte burst for code 0 is not two beats.");
	a_burst_len_max: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == dma_cfg_pkg::BURST_REQ && bus_grant && code_act_reg == 2'h3 && word_act_reg
		|=> beat_reg [*6] ##1 !beat_reg) else $error("Word burst for code 3 is not six beats.");
	a_cfg_hold_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		busy_reg && $past(busy_reg) |-> $stable(word_act_reg) && $stable(swap_act_reg) && $stable(wide_act_reg))
		else $error("Configuration changed during a burst.");
	a_rx_level_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == dma_cfg_pkg::BURST_IDLE && !tx_dir && cfg.fifo_code == 2'h2
		|=> bus_req_reg == ($past(fifo_level) >= 5'h08)) else $error("Receive request level wrong.");
	a_tx_level_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == dma_cfg_pkg::BURST_IDLE && tx_dir && cfg.fifo_code == 2'h0
		|=> bus_req_reg == ($past(fifo_level) >= 5'h0b)) else $error("Transmit request level wrong.");
	a_wide_upper: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == dma_cfg_pkg::BURST_IDLE
		|=> addr_reg[31:16] == ($past(cfg.wide_sel) ? $past(cfg.remote_addr) : 16'h0000))
		else $error("Upper address does not follow wide mode.");
endmodule

// ---- dma_data_config.sv ----
// Data configuration register bank with AXI4-Lite access, DMA data path and loopback selection.
// Assumes one clock, a synchronous active-low reset and a FIFO that reports its fill in bytes.
//
// Overview of operation
// - Transfer width bit 0 gives byte transfers and 1 gives word transfers for both DMA channels.
// - In word mode up to 32k words are addressed and address bit 0 stays low.
// - Lane order 0 puts the high byte on the upper lanes, order 1 swaps the two lanes.
// - Lane order is ignored while byte transfers are selected.
// - Wide address 0 gives two 16-bit channels, 1 gives one 32-bit mode with the remote start address on top.
// - Wide address powers up set, so 32-bit mode holds until software writes the register.
// - Loopback-off 0 selects loopback together with the loop type code, 1 selects normal operation.
// - With auto remote set the send command starts remote DMA, with it clear the command is not executed.
// - On receive the bus is requested at 2, 4, 8 or 12 bytes for codes 0 to 3.
// - On transmit the bus is requested at 13 bytes minus the receive level.
// - The burst length follows from the FIFO level code.
// - Loop type 0 is normal, 1 controller loopback, 2 encoder loopback, 3 external loopback.
`timescale 1ns/1ps
`include "dma_cfg_regs.svh"
module dma_data_config (
	input wire logic aclk, // System clock, 100 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic [4:0] fifo_level, // Bytes held in the FIFO.
	input wire logic [15:0] fifo_data, // FIFO word, high byte on bits 15:8.
	input wire logic tx_dir, // High while transmitting.
	input wire logic bus_grant, // System bus granted.
	input wire logic [15:0] local_start_addr, // Local DMA start address.
	input wire logic local_start_load, // Loads local_start_addr while idle.
	input wire logic send_cmd, // Send command pulse.
	output logic bus_request_out, // System bus request.
	output logic dma_beat, // One transfer this cycle.
	output logic [31:0] dma_addr, // DMA address.
	output logic [15:0] dma_data, // DMA data lanes.
	output logic dma_word_mode, // Word transfers in effect.
	output logic send_start, // Remote DMA auto start pulse.
	output logic loopback_active, // Loopback in effect.
	output logic [1:0] loop_mode, // Loop type in effect.
	output logic encoder_loop_pin // Encoder-decoder loopback request.
);
	cfg_if cfg ();

	logic [7:0] data_config_reg, data_config_next;
	logic [1:0] loop_type_reg, loop_type_next;
	logic [15:0] remote_addr_reg, remote_addr_next;

	logic awready_reg, awready_next, wready_reg, wready_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [5:0] aw_idx_reg, aw_idx_next;
	logic [15:0] w_data_reg, w_data_next;
	logic [1:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	logic [15:0] dma_data_reg, dma_data_next;
	logic send_start_reg, send_start_next;
	logic loop_act_reg, loop_act_next, enc_loop_reg, enc_loop_next;
	logic [1:0] loop_mode_reg, loop_mode_next;

	logic bus_req_w, beat_w, busy_w, word_act_w, swap_act_w, wide_act_w;
	logic [31:0] addr_w;
	logic [5:0] ar_idx;
	logic [7:0] status_val;

	assign cfg.word_sel = data_config_reg[`WIDTH_BIT];
	assign cfg.lane_swap = data_config_reg[`LANE_BIT];
	assign cfg.wide_sel = data_config_reg[`WIDE_BIT];
	assign cfg.fifo_code = {data_config_reg[`FIFO_HI_BIT], data_config_reg[`FIFO_LO_BIT]};
	assign cfg.remote_addr = remote_addr_reg;

	dma_burst_ctl burst (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(cfg.sink),
		.fifo_level(fifo_level),
		.tx_dir(tx_dir),
		.bus_grant(bus_grant),
		.start_addr(local_start_addr),
		.start_load(local_start_load),
		.bus_req_reg(bus_req_w),
		.beat_reg(beat_w),
		.busy_reg(busy_w),
		.word_act_reg(word_act_w),
		.swap_act_reg(swap_act_w),
		.wide_act_reg(wide_act_w),
		.addr_reg(addr_w)
	);

	// Register bus: one write and one read at a time; address and data may come in either order.
	always_comb begin
		aw_have_next = aw_have_reg;
		aw_idx_next = aw_idx_reg;
		w_have_next = w_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		data_config_next = data_config_reg;
		loop_type_next = loop_type_reg;
		remote_addr_next = remote_addr_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			aw_idx_next = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata[15:0];
			w_strb_next = s_axi_wstrb[1:0];
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `RESP_OKAY;
			case (aw_idx_reg)
				`DATA_CONFIG_IDX: begin
					if (w_strb_reg[0]) begin
						data_config_next = w_data_reg[7:0];
					end
				end
				`LOOP_TYPE_IDX: begin
					if (w_strb_reg[0]) begin
						loop_type_next = w_data_reg[1:0];
					end
				end
				`REMOTE_ADDR_IDX: begin
					if (w_strb_reg[0]) begin
						remote_addr_next[7:0] = w_data_reg[7:0];
					end
					if (w_strb_reg[1]) begin
						remote_addr_next[15:8] = w_data_reg[15:8];
					end
				end
				default: bresp_next = `RESP_SLVERR;
			endcase
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
			w_have_reg <= 1'b0;
			w_data_reg <= 16'h0000;
			w_strb_reg <= 2'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			data_config_reg <= `DATA_CONFIG_RESET;
			loop_type_reg <= `LOOP_TYPE_RESET;
			remote_addr_reg <= `REMOTE_ADDR_RESET;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_idx_reg <= aw_idx_next;
			w_have_reg <= w_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			data_config_reg <= data_config_next;
			loop_type_reg <= loop_type_next;
			remote_addr_reg <= remote_addr_next;
		end
	end

	// The configuration register is write-only and reads as zero.
	always_comb begin
		ar_idx = s_axi_araddr[7:2];
		status_val = 8'h00;
		status_val[`ST_WORD_BIT] = word_act_w;
		status_val[`ST_SWAP_BIT] = swap_act_w;
		status_val[`ST_WIDE_BIT] = wide_act_w;
		status_val[`ST_BUSY_BIT] = busy_w;
		status_val[`ST_REQ_BIT] = bus_req_w;
		status_val[`ST_LOOP_BIT] = loop_act_reg;
		status_val[`ST_AUTO_BIT] = data_config_reg[`AUTO_BIT];
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = `RESP_OKAY;
			case (ar_idx)
				`DATA_CONFIG_IDX: rdata_next = 32'h00000000;
				`LOOP_TYPE_IDX: rdata_next = {30'h0, loop_type_reg};
				`REMOTE_ADDR_IDX: rdata_next = {16'h0000, remote_addr_reg};
				`CFG_STATUS_IDX: rdata_next = {24'h000000, status_val};
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = `RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Data lanes, send command gating and loopback selection.
	always_comb begin
		if (!word_act_w) begin
			dma_data_next = {8'h00, fifo_data[7:0]};
		end else if (swap_act_w) begin
			dma_data_next = {fifo_data[7:0], fifo_data[15:8]};
		end else begin
			dma_data_next = fifo_data;
		end
		send_start_next = send_cmd && data_config_reg[`AUTO_BIT];
		loop_act_next = !data_config_reg[`LOOPOFF_BIT] && (loop_type_reg != dma_cfg_pkg::LOOP_NORMAL);
		loop_mode_next = data_config_reg[`LOOPOFF_BIT] ? dma_cfg_pkg::LOOP_NORMAL : loop_type_reg;
		enc_loop_next = (loop_mode_next == dma_cfg_pkg::LOOP_ENDEC);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_data_reg <= 16'h0000;
			send_start_reg <= 1'b0;
			loop_act_reg <= 1'b0;
			loop_mode_reg <= dma_cfg_pkg::LOOP_NORMAL;
			enc_loop_reg <= 1'b0;
		end else begin
			dma_data_reg <= dma_data_next;
			send_start_reg <= send_start_next;
			loop_act_reg <= loop_act_next;
			loop_mode_reg <= loop_mode_next;
			enc_loop_reg <= enc_loop_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign bus_request_out = bus_req_w;
	assign dma_beat = beat_w;
	assign dma_addr = addr_w;
	assign dma_data = dma_data_reg;
	assign dma_word_mode = word_act_w;
	assign send_start = send_start_reg;
	assign loopback_active = loop_act_reg;
	assign loop_mode = loop_mode_reg;
	assign encoder_loop_pin = enc_loop_reg;

	a_lane_order_swap: assert property (@(posedge aclk) disable iff (!aresetn)
		word_act_w && swap_act_w |=> dma_data == {$past(fifo_data[7:0]), $past(fifo_data[15:8])})
		else $error("Swapped lane order not applied.");
	a_byte_ignore_order: assert property (@(posedge aclk) disable iff (!aresetn)
		!word_act_w |=> dma_data == {8'h00, $past(fifo_data[7:0])})
		else $error("Byte mode did not ignore lane order.");
	a_reset_wide_set: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(aresetn) |-> cfg.wide_sel && wide_act_w) else $error("Wide addressing not set after reset.");
	a_send_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		send_cmd |=> send_start == $past(data_config_reg[`AUTO_BIT]))
		else $error("Send command gating wrong.");
	a_loop_select: assert property (@(posedge aclk) disable iff (!aresetn)
		data_config_reg[`LOOPOFF_BIT] |=> !loopback_active && loop_mode == dma_cfg_pkg::LOOP_NORMAL)
		else $error("Loopback active in normal operation.");
	a_encoder_loop: assert property (@(posedge aclk) disable iff (!aresetn)
		!data_config_reg[`LOOPOFF_BIT] && loop_type_reg == dma_cfg_pkg::LOOP_ENDEC |=> encoder_loop_pin)
		else $error("Encoder loopback not requested.");
endmodule

// ---- dma_bus_partner.sv ----
// System bus arbiter model that answers the block's bus request.
// Assumes one clock shared with the block and a synchronous active-low reset.
`timescale 1ns/1ps
module dma_bus_partner (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic bus_request_out, // Request from the block.
	input wire logic [3:0] grant_delay, // Cycles to stall before granting.
	output logic bus_grant // Grant back to the block.
);
	logic [3:0] wait_reg;

	// The grant is withdrawn as soon as the request drops, so a late grant never leaks into the next burst.
	always_ff @(posedge aclk) begin
		if (!aresetn || !bus_request_out) begin
			wait_reg <= 4'h0;
			bus_grant <= 1'b0;
		end else if (wait_reg >= grant_delay) begin
			bus_grant <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule

// ---- dma_data_configuration_bench.sv ----
// Self-checking bench for the DMA data configuration block.
// Assumes the design files and the bus partner model are compiled before it.
`timescale 1ns/1ps
module dma_data_configuration_bench;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, dma_addr;
	logic [3:0] s_axi_wstrb = 4'hf, grant_delay = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_grant;
	logic [1:0] s_axi_bresp, s_axi_rresp, loop_mode;
	logic [4:0] fifo_level = 0;
	logic [15:0] fifo_data = 16'ha55a, local_start_addr = 16'h0100, dma_data;
	logic tx_dir = 0, local_start_load = 0, send_cmd = 0;
	logic bus_request_out, dma_beat, dma_word_mode, send_start, loopback_active, encoder_loop_pin;
	int err_total = 0;
	int num_checks = 0;

	always #5 aclk = ~aclk;

	dma_data_config u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fifo_level,
		.fifo_data, .tx_dir, .bus_grant, .local_start_addr, .local_start_load, .send_cmd, .bus_request_out,
		.dma_beat, .dma_addr, .dma_data, .dma_word_mode, .send_start, .loopback_active, .loop_mode,
		.encoder_loop_pin);
	dma_bus_partner u_bus (.aclk, .aresetn, .bus_request_out, .grant_delay, .bus_grant);

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// Waits for a design output to be sampled high at a rising edge.
	task automatic wait_hi(ref logic s);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (s === 1'b1)
				break;
		end
		if (i >= 60) begin
			err_total++;
			$display("CHECK FAILED %0t wait timed out", $time);
			stop_test();
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		int i;
		aw = 1;
		w = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (i = 0; i < 60 && (aw || w); i++) begin
			@(posedge aclk);
			aw = aw && s_axi_awready !== 1'b1;
			w = w && s_axi_wready !== 1'b1;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		wait_hi(s_axi_bvalid);
		s_axi_bready <= 0;
		cmp(s_axi_bresp, er, "write response");
		// One edge passes so that a following call never raises bready in the step that lowered it.
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		wait_hi(s_axi_arready);
		s_axi_arvalid <= 0;
		wait_hi(s_axi_rvalid);
		s_axi_rready <= 0;
		cmp(s_axi_rresp, er, "read response");
		if (er == 2'h0)
			cmp(s_axi_rdata, ed, "read data");
		@(posedge aclk);
	endtask

	task automatic t_regs;
		axr(8'h50, 32'h04, 2'h0);
		axr(8'h38, 32'h0, 2'h0);
		axr(8'h5c, 32'h0, 2'h2);
		axw(8'h50, 32'h1, 2'h2);
		axw(8'h48, 32'h1234, 2'h0);
		axw(8'h38, 32'h0c, 2'h0);
		repeat (3) @(posedge aclk);
		cmp(dma_addr[31:16], 16'h1234, "wide upper address");
		axw(8'h38, 32'h08, 2'h0);
		repeat (3) @(posedge aclk);
		cmp(dma_addr[31:16], 16'h0, "dual upper address");
		$display("test registers done");
	endtask

	task automatic burst(input logic [1:0] code, input logic word, input logic tx);
		int lvl, n, cnt;
		lvl = code == 2'h3 ? 12 : 2 << code;
		n = word ? lvl / 2 : lvl;
		if (tx)
			lvl = 13 - lvl;
		axw(8'h38, {25'h0, code, 5'h08 | 5'(word)}, 2'h0);
		tx_dir <= tx;
		grant_delay <= {2'h0, code};
		local_start_load <= 1;
		fifo_level <= 5'(lvl - 1);
		@(posedge aclk);
		local_start_load <= 0;
		repeat (3) @(posedge aclk);
		cmp(bus_request_out, 0, "request below level");
		fifo_level <= 5'(lvl);
		wait_hi(bus_request_out);
		fifo_level <= 0;
		cnt = 0;
		repeat (30) begin
			@(posedge aclk);
			if (dma_beat === 1'b1) begin
				cmp(dma_addr, 32'h100 + cnt * (word ? 2 : 1), "beat address");
				cmp(dma_word_mode, word, "width");
				cnt++;
			end
		end
		cmp(cnt, n, "beat count");
	endtask

	task automatic t_lanes;
		logic [7:0] cf[3] = '{8'h0b, 8'h09, 8'h0a};
		logic [15:0] ex[3] = '{16'h5aa5, 16'ha55a, 16'h005a};
		for (int i = 0; i < 3; i++) begin
			axw(8'h38, 32'(cf[i]), 2'h0);
			repeat (3) @(posedge aclk);
			cmp(dma_data, ex[i], "lanes");
		end
		$display("test lanes done");
	endtask

	task automatic t_loop;
		axw(8'h38, 32'h0, 2'h0);
		for (int t = 0; t < 4; t++) begin
			axw(8'h4c, t, 2'h0);
			repeat (2) @(posedge aclk);
			cmp({encoder_loop_pin, loopback_active, loop_mode}, {t == 2, t != 0, 2'(t)}, "loop");
		end
		axw(8'h38, 32'h08, 2'h0);
		repeat (2) @(posedge aclk);
		cmp({encoder_loop_pin, loopback_active}, 0, "normal");
		$display("test loopback done");
	endtask

	task automatic t_send;
		// Send is only used with the normal lane order.
		logic [7:0] cf[2] = '{8'h18, 8'h08};
		for (int i = 0; i < 2; i++) begin
			axw(8'h38, 32'(cf[i]), 2'h0);
			send_cmd <= 1;
			@(posedge aclk);
			send_cmd <= 0;
			@(posedge aclk);
			cmp(send_start, cf[i][4], "send start");
		end
		$display("test send done");
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs();
		for (int k = 0; k < 8; k++)
			burst(2'(k), k[0] ^ k[2], k[2]);
		$display("test bursts done");
		t_lanes();
		t_loop();
		t_send();
		stop_test();
	end
endmodule
